// [fcpf_top.sv]
// Packet FIFO data path between the host memory port and the transform core.
`timescale 1ns/1ns
module fcpf_top (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Host memory port, data
  input  wire logic                        host_wr,
  input  wire logic [fcpf_pkg::DATA_W-1:0] host_wdata,
  output logic                             host_wr_ready,
  input  wire logic                        host_rd,
  output logic [fcpf_pkg::DATA_W-1:0]      host_rdata,
  // Host memory port, control word
  input  wire logic                        ctl_wr,
  input  wire logic [fcpf_pkg::DATA_W-1:0] ctl_wdata,
  output logic                             soft_reset,
  // DMA event requests, active low
  output logic                             tx_dma_req_n,
  output logic                             rx_dma_req_n,
  // Stream to the transform core
  output logic                             tx_valid,
  input  wire logic                        tx_ready,
  output logic [fcpf_pkg::DATA_W-1:0]      tx_data,
  output logic                             tx_sop,
  output logic                             tx_eop,
  // Stream from the transform core
  input  wire logic                        rx_valid,
  output logic                             rx_ready,
  input  wire logic [fcpf_pkg::DATA_W-1:0] rx_data
);
  fcpf_fifo_if txf ();
  fcpf_fifo_if rxf ();

  fcpf_fifo u_tx_fifo (
    .clk (clk),
    .rst (rst),
    .f   (txf.fifo)
  );
  fcpf_fifo u_rx_fifo (
    .clk (clk),
    .rst (rst),
    .f   (rxf.fifo)
  );

  fcpf_pkg::fcpf_tx_state_t      st_r, st_nxt;
  logic [9:0]                    idx_r, idx_nxt;
  logic [fcpf_pkg::CREDIT_W-1:0] credit_r, credit_nxt;
  logic                          srst_r, srst_nxt;
  logic                          txreq_r, txreq_nxt;
  logic                          rxreq_r, rxreq_nxt;
  logic [fcpf_pkg::DATA_W-1:0]   rdata_r, rdata_nxt;
  logic                          tx_fire, pkt_done, cinc;

  // -----------------------------------------------------------------
  // Host side of both FIFOs
  // -----------------------------------------------------------------
  // Clearing one cycle after the control write keeps the soft reset a
  // clean registered pulse that also reaches the outside.
  assign txf.clr     = srst_r;
  assign rxf.clr     = srst_r;
  // The host DMA is paced by host_wr_ready; words offered while full are dropped.
  assign txf.wr_en   = host_wr && !txf.full;
  assign txf.wr_data = host_wdata;
  assign host_wr_ready = !txf.full;
  assign rxf.rd_en   = host_rd;
  assign host_rdata  = rdata_r;

  // -----------------------------------------------------------------
  // Transmit stream to the core
  // -----------------------------------------------------------------
  assign tx_valid  = (st_r == fcpf_pkg::FCPF_SEND);
  assign tx_data   = txf.rd_data;
  assign tx_sop    = tx_valid && (idx_r == '0);
  assign tx_eop    = tx_valid && (idx_r == fcpf_pkg::LAST_IDX);
  assign tx_fire   = tx_valid && tx_ready;
  assign pkt_done  = tx_fire && tx_eop;
  assign txf.rd_en = tx_fire;

  // -----------------------------------------------------------------
  // Receive stream from the core
  // -----------------------------------------------------------------
  assign rxf.wr_en   = rx_valid && !rxf.full;
  assign rxf.wr_data = rx_data;
  assign rx_ready    = !rxf.full;

  assign cinc = ctl_wr && ctl_wdata[fcpf_pkg::BIT_CINC];

  always_comb begin
    st_nxt     = st_r;
    idx_nxt    = idx_r;
    credit_nxt = credit_r;
    rdata_nxt  = rdata_r;
    unique case (st_r)
      fcpf_pkg::FCPF_IDLE: begin
        idx_nxt = '0;
        // Launch only once the threshold says a whole packet is queued.
        if (txf.count >= fcpf_pkg::AVAIL_CNT) begin
          st_nxt = fcpf_pkg::FCPF_SEND;
        end
      end
      fcpf_pkg::FCPF_SEND: begin
        if (tx_fire) begin
          idx_nxt = idx_r + 10'h001;
        end
        if (pkt_done) begin
          st_nxt = fcpf_pkg::FCPF_IDLE;
        end
      end
      default: begin
        st_nxt = fcpf_pkg::FCPF_IDLE;
      end
    endcase
    // Add and take in the same cycle cancel; count saturates at both ends.
    if (cinc && !pkt_done && (credit_r != '1)) begin
      credit_nxt = credit_r + 8'h01;
    end else if (pkt_done && !cinc && (credit_r != '0)) begin
      credit_nxt = credit_r - 8'h01;
    end
    if (host_rd) begin
      rdata_nxt = rxf.empty ? '0 : rxf.rd_data;
    end
    srst_nxt = ctl_wr && ctl_wdata[fcpf_pkg::BIT_SRST];
    // Request only while the port is idle and a packet of room is free,
    // so the host writing packet n+1 overlaps transform of packet n.
    txreq_nxt = (credit_r != '0) && !host_wr && !host_rd && !ctl_wr
                && (txf.count <= fcpf_pkg::ROOM_CNT);
    rxreq_nxt = (rxf.count >= fcpf_pkg::AVAIL_CNT);
    if (srst_r) begin
      st_nxt     = fcpf_pkg::FCPF_IDLE;
      idx_nxt    = '0;
      credit_nxt = '0;
      txreq_nxt  = 1'b0;
      rxreq_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r     <= fcpf_pkg::FCPF_IDLE;
      idx_r    <= '0;
      credit_r <= '0;
      srst_r   <= 1'b0;
      txreq_r  <= 1'b0;
      rxreq_r  <= 1'b0;
      rdata_r  <= '0;
    end else begin
      st_r     <= st_nxt;
      idx_r    <= idx_nxt;
      credit_r <= credit_nxt;
      srst_r   <= srst_nxt;
      txreq_r  <= txreq_nxt;
      rxreq_r  <= rxreq_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign soft_reset   = srst_r;
  assign tx_dma_req_n = !txreq_r;
  assign rx_dma_req_n = !rxreq_r;
endmodule

// [fcpf_pkg.sv]
// Constants shared by the packet FIFO data path.
package fcpf_pkg;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned DEPTH     = 2048;
  localparam int unsigned PTR_W     = 11;
  localparam int unsigned CNT_W     = 12;
  localparam int unsigned PKT_WORDS = 1024;
  localparam int unsigned THRESH    = 1022;
  localparam int unsigned CREDIT_W  = 8;
  localparam int unsigned BIT_SRST  = 0;
  localparam int unsigned BIT_CINC  = 1;
  localparam logic [CNT_W-1:0] PKT_CNT   = CNT_W'(PKT_WORDS);
  localparam logic [CNT_W-1:0] AVAIL_CNT = CNT_W'(THRESH + 2);
  localparam logic [CNT_W-1:0] ROOM_CNT  = CNT_W'(DEPTH - PKT_WORDS);
  localparam logic [CNT_W-1:0] FULL_CNT  = CNT_W'(DEPTH);
  localparam logic [9:0]       LAST_IDX  = 10'(PKT_WORDS - 1);
  typedef enum logic [1:0] {
    FCPF_IDLE = 2'b01,
    FCPF_SEND = 2'b10
  } fcpf_tx_state_t;
endpackage

// [fcpf_fifo_if.sv]
// Interface between the top and one FIFO instance.
`timescale 1ns/1ns
interface fcpf_fifo_if;
  logic                                 clr;
  logic                                 wr_en;
  logic [fcpf_pkg::DATA_W-1:0]          wr_data;
  logic                                 rd_en;
  logic [fcpf_pkg::DATA_W-1:0]          rd_data;
  logic                                 full;
  logic                                 empty;
  logic [fcpf_pkg::CNT_W-1:0]           count;
  modport ctrl (output clr, output wr_en, output wr_data, output rd_en,
                input rd_data, input full, input empty, input count);
  modport fifo (input clr, input wr_en, input wr_data, input rd_en,
                output rd_data, output full, output empty, output count);
endinterface

// [fcpf_fifo.sv]
// Flip-flop FIFO with show-ahead read data and a fill count.
`timescale 1ns/1ns
module fcpf_fifo (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Port to the controller
  fcpf_fifo_if.fifo f
);
  logic [fcpf_pkg::DATA_W-1:0] mem [fcpf_pkg::DEPTH];
  logic [fcpf_pkg::PTR_W-1:0]  wp_r, wp_nxt, rp_r, rp_nxt;
  logic [fcpf_pkg::CNT_W-1:0]  cnt_r, cnt_nxt;
  logic                        do_wr, do_rd;

  // -----------------------------------------------------------------
  // Pointer and count update
  // -----------------------------------------------------------------
  function automatic logic [fcpf_pkg::PTR_W-1:0] ptr_one(input logic b);
    ptr_one = {{(fcpf_pkg::PTR_W-1){1'b0}}, b};
  endfunction

  always_comb begin
    do_wr   = f.wr_en && (cnt_r != fcpf_pkg::FULL_CNT);
    do_rd   = f.rd_en && (cnt_r != '0);
    wp_nxt  = wp_r + ptr_one(do_wr);
    rp_nxt  = rp_r + ptr_one(do_rd);
    cnt_nxt = cnt_r + {{(fcpf_pkg::CNT_W-1){1'b0}}, do_wr} - {{(fcpf_pkg::CNT_W-1){1'b0}}, do_rd};
    if (f.clr) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // A write into a full FIFO is dropped here, never overwriting data.
  always_ff @(posedge clk) begin
    if (do_wr && !f.clr) begin
      mem[wp_r] <= f.wr_data;
    end
  end

  assign f.rd_data = mem[rp_r];
  assign f.full    = (cnt_r == fcpf_pkg::FULL_CNT);
  assign f.empty   = (cnt_r == '0);
  assign f.count   = cnt_r;
endmodule

// [fcpf_props.sv]
// Checker of the packet FIFO data path, bound to its top module.
`timescale 1ns/1ns
module fcpf_props (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        host_wr,
  input wire logic                        host_wr_ready,
  input wire logic                        host_rd,
  input wire logic                        ctl_wr,
  input wire logic [fcpf_pkg::DATA_W-1:0] ctl_wdata,
  input wire logic                        soft_reset,
  input wire logic                        tx_dma_req_n,
  input wire logic                        rx_dma_req_n,
  input wire logic                        tx_valid,
  input wire logic                        tx_ready,
  input wire logic [fcpf_pkg::DATA_W-1:0] tx_data,
  input wire logic                        tx_sop,
  input wire logic                        tx_eop,
  input wire logic                        rx_valid,
  input wire logic                        rx_ready
);
  int   txc_r, txc_nxt, rxc_r, rxc_nxt, wc_r, wc_nxt;
  logic tk;
  // Shadow fill counts; the soft reset pulse clears them at the edge it is seen.
  always_comb begin
    tk = tx_valid && tx_ready;
    txc_nxt = soft_reset ? 0 : txc_r + int'(host_wr && host_wr_ready) - int'(tk);
    rxc_nxt = soft_reset ? 0 : rxc_r + int'(rx_valid && rx_ready) - int'(host_rd && rxc_r != 0);
    wc_nxt = (soft_reset || (tk && tx_eop)) ? 0 : wc_r + int'(tk);
  end
  always_ff @(posedge clk) begin
    txc_r <= rst ? 0 : txc_nxt;
    rxc_r <= rst ? 0 : rxc_nxt;
    wc_r <= rst ? 0 : wc_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_sop; tx_valid |-> tx_sop == (wc_r == 0); endproperty
  a_sop: assert property (p_sop) else $error("start marker misplaced");
  property p_eop; tx_valid |-> tx_eop == (wc_r == 1023); endproperty
  a_eop: assert property (p_eop) else $error("end marker misplaced");
  property p_hold; tx_valid && !tx_ready && !soft_reset |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  property p_gap; tk && tx_eop |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no gap after packet");
  property p_start; $rose(tx_valid) |-> $past(txc_r) >= 1024; endproperty
  a_start: assert property (p_start) else $error("packet sent before complete");
  property p_wfull; host_wr_ready == (txc_r != 2048); endproperty
  a_wfull: assert property (p_wfull) else $error("write ready wrong");
  property p_rfull; rx_ready == (rxc_r != 2048); endproperty
  a_rfull: assert property (p_rfull) else $error("receive ready wrong");
  property p_rxreq; !$past(soft_reset) |-> rx_dma_req_n == ($past(rxc_r) < 1024); endproperty
  a_rxreq: assert property (p_rxreq) else $error("receive request wrong");
  property p_srst; ctl_wr && ctl_wdata[0] |=> soft_reset ##1
    (host_wr_ready && rx_ready && !tx_valid && tx_dma_req_n); endproperty
  a_srst: assert property (p_srst) else $error("soft reset incomplete");
endmodule
bind fcpf_top fcpf_props fcpf_props_i (.clk, .rst, .host_wr, .host_wr_ready, .host_rd, .ctl_wr,
  .ctl_wdata, .soft_reset, .tx_dma_req_n, .rx_dma_req_n, .tx_valid, .tx_ready, .tx_data,
  .tx_sop, .tx_eop, .rx_valid, .rx_ready);

// [fcpf_core_model.sv]
// Behavioural transform core that returns each packet with every word inverted.
`timescale 1ns/1ns
module fcpf_core_model (
  // Clock, reset and stall control
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        stall,
  // Streams to and from the block
  input  wire logic                        tx_valid,
  input  wire logic                        tx_eop,
  input  wire logic [fcpf_pkg::DATA_W-1:0] tx_data,
  output logic                             tx_ready,
  output logic                             rx_valid,
  input  wire logic                        rx_ready,
  output logic [fcpf_pkg::DATA_W-1:0]      rx_data
);
  logic [fcpf_pkg::DATA_W-1:0] q[$];
  int                          pend;
  logic                        nv;
  // Output starts only after the last word, so the block sees burst-like gaps.
  always @(posedge clk) begin
    if (rst) begin
      q.delete();
      pend = 0;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      if (rx_valid && rx_ready) begin
        q.delete(0);
        pend--;
      end
      if (tx_valid && tx_ready) q.push_back(~tx_data);
      if (tx_valid && tx_ready && tx_eop) pend += fcpf_pkg::PKT_WORDS;
      nv = (rx_valid && !rx_ready) || (pend > 0 && !stall);
      tx_ready <= !stall;
      rx_valid <= nv;
      rx_data <= nv ? q[0] : ~rx_data;
    end
  end
endmodule

// [test_fcpf_top.sv]
// Self-checking bench of the packet FIFO data path with a core model.
`timescale 1ns/1ns
module test_fcpf_top;
  logic clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, ctl_wr = 1'b0, stall = 1'b0;
  logic [fcpf_pkg::DATA_W-1:0] host_wdata = '0, ctl_wdata = '0, host_rdata, tx_data, rx_data;
  logic host_wr_ready, soft_reset, tx_dma_req_n, rx_dma_req_n, tx_valid, tx_ready, tx_sop;
  logic tx_eop, rx_valid, rx_ready;
  int   errors = 0, comparisons = 0, cycles = 0;
  // The host port spends five clocks on each data read or write; a control write spends three.
  localparam int ACC_CLKS = 5;
  always #5 clk = ~clk;
  fcpf_top fcpf_top_i (.clk, .rst, .host_wr, .host_wdata, .host_wr_ready, .host_rd, .host_rdata,
    .ctl_wr, .ctl_wdata, .soft_reset, .tx_dma_req_n, .rx_dma_req_n, .tx_valid, .tx_ready,
    .tx_data, .tx_sop, .tx_eop, .rx_valid, .rx_ready, .rx_data);
  fcpf_core_model fcpf_core_model_i (.clk, .rst(rst || soft_reset), .stall, .tx_valid, .tx_eop,
    .tx_data, .tx_ready, .rx_valid, .rx_ready, .rx_data);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Host port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      host_wr    <= 1'b1;
      host_wdata <= base + 32'(i);
      @(posedge clk);
      host_wr <= 1'b0;
      repeat (ACC_CLKS - 1) @(posedge clk);
    end
  endtask
  task automatic rd(input logic [31:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
      @(posedge clk);
      chk(host_rdata, ~(base + 32'(i)));
      repeat (ACC_CLKS - 2) @(posedge clk);
    end
  endtask
  task automatic ctl(input logic [31:0] w);
    ctl_wr <= 1'b1;
    ctl_wdata <= w;
    @(posedge clk);
    ctl_wr <= 1'b0;
    stall <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_rx();
    for (int k = 0; k < 4000 && rx_dma_req_n !== 1'b0; k++) @(posedge clk);
    chk(rx_dma_req_n, 1'b0);
  endtask
  // Holds back one word short of a packet, then overlaps the next write.
  task automatic t_pipe();
    ctl(32'h0000_0002);
    chk(tx_dma_req_n, 1'b0);
    wr(32'h1000_0000, 1023);
    repeat (3) @(posedge clk);
    chk(tx_valid, 1'b0);
    wr(32'h1000_03FF, 1);
    repeat (2) @(posedge clk);
    chk(tx_valid, 1'b1);
    wr(32'h2000_0000, 1024);
    wait_rx();
    rd(32'h1000_0000, 1024);
    wait_rx();
    rd(32'h2000_0000, 1024);
    rd(32'hFFFF_FFFF, 1);
    chk(tx_dma_req_n, 1'b1);
  endtask
  task automatic t_full();
    stall <= 1'b1;
    wr(32'h3000_0000, 2049);
    chk(host_wr_ready, 1'b0);
    ctl(32'h0000_0001);
    chk({host_wr_ready, tx_valid, rx_dma_req_n}, 32'h5);
    wr(32'h4000_0000, 1024);
    wait_rx();
    rd(32'h4000_0000, 1024);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({host_wr_ready, rx_ready, tx_valid, tx_dma_req_n, rx_dma_req_n}, 32'h1B);
    chk(host_rdata, 32'h0);
    t_pipe();
    t_full();
    tally_and_finish();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
endmodule
